/* File: src/serial_loopback_self_test.sv */
// loopback self-test sequencer with its expected-character fifo
// assumes adapter status and data are on ref_clk_i; modem lines dcd/cts are raw pins
//
// Overview of operation
// - reset adapter, then configure 9600 baud, 8 data bits, 1 stop, 16x clock.
// - with rts high, carrier detect must read high, else code C1.
// - with rts still high, clear-to-send must read high, else code C2.
// - drive rts low; carrier detect must read low, else code C3.
// - with rts low, clear-to-send must read low, else code C4 stays shown.
// - send 256 characters 00 to FF in order at 9600 and receive each back.
// - poll adapter receive-full status; set means an echoed character waits.
// - compare each echo with its sent character; mismatch or missing gives C5.
// - then reconfigure for 300 baud and repeat the transfer; failure gives C6.
// - run a program-memory checksum; a wrong sum gives code C8.
// - show each step code as it begins; on failure keep code, repeat step.
// - after every step passes, show completion code 55.
`timescale 1ns/1ps

module loopback_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= AW'(rd_ptr + 1'b1);
            end
            count <= (AW+1)'(count + (push ? 1 : 0) - (pop ? 1 : 0));
        end
    end
endmodule

module serial_loopback_self_test
    import serial_loopback_self_test_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = RX_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // adapter control and configuration
    output logic adapter_reset_o,
    output logic cfg_write_o,
    output logic cfg_baud_o,
    output logic [3:0] cfg_data_bits_o,
    output logic [1:0] cfg_stop_bits_o,
    output logic [4:0] cfg_clk_mult_o,
    // modem control lines through the plug
    output logic rts_o,
    input wire logic dcd_i,
    input wire logic cts_i,
    // adapter transmit and receive
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic rx_full_i,
    input wire logic [7:0] rx_data_i,
    output logic rx_read_o,
    // program memory, one cycle read latency
    output logic [ROM_AW-1:0] rom_addr_o,
    input wire logic [7:0] rom_data_i,
    // front panel code display and status
    output logic [7:0] front_panel_code_display_o,
    output logic fail_o,
    output logic done_o
);
    typedef enum logic [2:0] {S_ARESET, S_CONFIG, S_CTRL, S_XFER, S_CKSUM, S_DONE} state_t;

    state_t state_reg;
    logic [31:0] timer_reg;
    logic [31:0] wait_reg;
    logic [1:0] ctrl_idx_reg;
    logic rate_slow_reg;
    logic drain_reg;
    logic [8:0] sent_reg;
    logic [8:0] recv_reg;
    logic [10:0] iss_reg;
    logic rom_vld_reg;
    logic [7:0] sum_reg;
    logic dcd_meta, dcd_s, cts_meta, cts_s;
    logic fifo_ready, exp_valid, flush;
    logic [7:0] exp_data;
    logic can_send, rx_take, rx_bad, timed_out, ctrl_check, ctrl_bad, ck_end;

    // two-flop synchronisers for the looped modem lines
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dcd_meta <= 1'b0;
            dcd_s <= 1'b0;
            cts_meta <= 1'b0;
            cts_s <= 1'b0;
        end else begin
            dcd_meta <= dcd_i;
            dcd_s <= dcd_meta;
            cts_meta <= cts_i;
            cts_s <= cts_meta;
        end
    end

    // even sub-steps read carrier detect, odd ones clear-to-send; both must follow rts
    assign ctrl_check = (state_reg == S_CTRL) && (timer_reg == 32'h0000_0000);
    assign ctrl_bad = ctrl_check && (((ctrl_idx_reg[0] ? cts_s : dcd_s)) != rts_o);
    // only one tx strobe in flight, so a stale tx_ready_i cannot double-send
    // no strobe in the cycle a pass is abandoned, or a stale byte would reach the plug
    assign can_send = (state_reg == S_XFER) && (sent_reg != CHAR_COUNT) && tx_ready_i && fifo_ready && !tx_valid_o
        && !drain_reg && !rx_bad && !flush;
    assign rx_take = (state_reg == S_XFER) && rx_full_i && !rx_read_o;
    assign rx_bad = rx_take && !drain_reg && (!exp_valid || (rx_data_i != exp_data));
    assign timed_out = (state_reg == S_XFER) && exp_valid && (wait_reg >= TIMEOUT_CYC);
    // only lost bytes flush the fifo; after a bad byte the rest still come back and are drained
    assign flush = (state_reg == S_XFER) && timed_out;
    assign ck_end = (state_reg == S_CKSUM) && (iss_reg == ROM_WORDS) && !rom_vld_reg;

    loopback_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_expect (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .flush_i(flush),
        .in_valid_i(can_send),
        .in_ready_o(fifo_ready),
        .in_data_i(sent_reg[7:0]),
        .out_valid_o(exp_valid),
        .out_ready_i(rx_take),
        .out_data_o(exp_data)
    );

    // step sequencing, display code and failure flag
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= S_ARESET;
            timer_reg <= ARESET_CYC;
            ctrl_idx_reg <= 2'h0;
            rate_slow_reg <= 1'b0;
            adapter_reset_o <= 1'b1;
            cfg_write_o <= 1'b0;
            rts_o <= 1'b0;
            front_panel_code_display_o <= CODE_IDLE;
            fail_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cfg_write_o <= 1'b0;
            unique case (state_reg)
                S_ARESET: begin
                    if (timer_reg == 32'h0000_0000) begin
                        adapter_reset_o <= 1'b0;
                        state_reg <= S_CONFIG;
                    end else begin
                        timer_reg <= timer_reg - 1;
                    end
                end
                S_CONFIG: begin
                    cfg_write_o <= 1'b1;
                    timer_reg <= SETTLE_CYC;
                    if (rate_slow_reg) begin
                        state_reg <= S_XFER;
                        front_panel_code_display_o <= CODE_C6;
                    end else begin
                        state_reg <= S_CTRL;
                        ctrl_idx_reg <= 2'h0;
                        rts_o <= 1'b1;
                        front_panel_code_display_o <= CODE_C1;
                    end
                end
                S_CTRL: begin
                    if (!ctrl_check) begin
                        timer_reg <= timer_reg - 1;
                    end else if (ctrl_bad) begin
                        fail_o <= 1'b1;
                        timer_reg <= SETTLE_CYC;
                    end else if (ctrl_idx_reg == 2'h3) begin
                        fail_o <= 1'b0;
                        state_reg <= S_XFER;
                        front_panel_code_display_o <= CODE_C5;
                    end else begin
                        fail_o <= 1'b0;
                        ctrl_idx_reg <= 2'(ctrl_idx_reg + 1'b1);
                        rts_o <= (ctrl_idx_reg == 2'h0);
                        timer_reg <= SETTLE_CYC;
                        front_panel_code_display_o <= 8'(CODE_C1 + ctrl_idx_reg + 1'b1);
                    end
                end
                S_XFER: begin
                    if (rx_bad || timed_out) begin
                        fail_o <= 1'b1;
                    end else if (rx_take && (recv_reg == 9'(CHAR_COUNT - 1'b1))) begin
                        fail_o <= 1'b0;
                        if (rate_slow_reg) begin
                            state_reg <= S_CKSUM;
                            front_panel_code_display_o <= CODE_C8;
                        end else begin
                            rate_slow_reg <= 1'b1;
                            state_reg <= S_CONFIG;
                        end
                    end
                end
                S_CKSUM: begin
                    if (ck_end) begin
                        if (sum_reg != CHECKSUM_EXPECT) begin
                            fail_o <= 1'b1;
                        end else begin
                            fail_o <= 1'b0;
                            done_o <= 1'b1;
                            state_reg <= S_DONE;
                            front_panel_code_display_o <= CODE_DONE;
                        end
                    end
                end
                S_DONE: begin
                end
            endcase
        end
    end

    // adapter configuration fields, written with each configure strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_baud_o <= BAUD_9600;
            cfg_data_bits_o <= CFG_DATA_BITS;
            cfg_stop_bits_o <= CFG_STOP_BITS;
            cfg_clk_mult_o <= CFG_CLK_MULT;
        end else if (state_reg == S_CONFIG) begin
            cfg_baud_o <= rate_slow_reg ? BAUD_300 : BAUD_9600;
            cfg_data_bits_o <= CFG_DATA_BITS;
            cfg_stop_bits_o <= CFG_STOP_BITS;
            cfg_clk_mult_o <= CFG_CLK_MULT;
        end
    end

    // echoes still in flight after a bad byte are taken but not compared, so a retry starts clean
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drain_reg <= 1'b0;
        end else if (state_reg != S_XFER || !exp_valid) begin
            drain_reg <= 1'b0;
        end else if (rx_bad) begin
            drain_reg <= 1'b1;
        end
    end

    // character transfer; a failed pass restarts from 00 once the plug is empty
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sent_reg <= 9'h000;
            recv_reg <= 9'h000;
            wait_reg <= 32'h0000_0000;
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
            rx_read_o <= 1'b0;
        end else begin
            tx_valid_o <= can_send;
            rx_read_o <= rx_take;
            if (state_reg != S_XFER || flush || rx_bad) begin
                sent_reg <= 9'h000;
                recv_reg <= 9'h000;
                wait_reg <= 32'h0000_0000;
            end else begin
                if (can_send) begin
                    tx_data_o <= sent_reg[7:0];
                    sent_reg <= 9'(sent_reg + 1'b1);
                end
                if (rx_take && !drain_reg) begin
                    recv_reg <= 9'(recv_reg + 1'b1);
                end
                wait_reg <= (rx_take || !exp_valid) ? 32'h0000_0000 : wait_reg + 1;
            end
        end
    end

    // program memory sum, one read per cycle, pipelined against the read latency
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            iss_reg <= 11'h000;
            rom_vld_reg <= 1'b0;
            rom_addr_o <= '0;
            sum_reg <= 8'h00;
        end else if (state_reg != S_CKSUM || ck_end) begin
            iss_reg <= 11'h000;
            rom_vld_reg <= 1'b0;
            rom_addr_o <= '0;
            sum_reg <= 8'h00;
        end else begin
            rom_vld_reg <= (iss_reg != ROM_WORDS);
            if (iss_reg != ROM_WORDS) begin
                iss_reg <= 11'(iss_reg + 1'b1);
                rom_addr_o <= ROM_AW'(rom_addr_o + 1'b1);
            end
            if (rom_vld_reg) begin
                sum_reg <= 8'(sum_reg + rom_data_i);
            end
        end
    end

    sequence cfg_strobe_s;
        cfg_write_o && cfg_data_bits_o == CFG_DATA_BITS && cfg_stop_bits_o == CFG_STOP_BITS;
    endsequence

    a_cfg_after_reset: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $fell(adapter_reset_o) |-> ##1 cfg_strobe_s ##0 cfg_clk_mult_o == CFG_CLK_MULT && cfg_baud_o == BAUD_9600)
        else $error("configure did not follow adapter reset");
    a_dcd_high_fail: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_check && ctrl_idx_reg == 2'h0 && !dcd_s |=> fail_o && front_panel_code_display_o == CODE_C1)
        else $error("carrier low with rts high not flagged C1");
    a_cts_high_fail: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_check && ctrl_idx_reg == 2'h1 && !cts_s |=> fail_o && front_panel_code_display_o == 8'hC2 && rts_o)
        else $error("cts low with rts high not flagged C2");
    a_dcd_low_check: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_check && ctrl_idx_reg == 2'h2 |-> !rts_o && front_panel_code_display_o == 8'hC3)
        else $error("carrier low check made with rts high");
    a_cts_low_stays: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_check && ctrl_idx_reg == 2'h3 && cts_s |=> fail_o [*2] ##0 front_panel_code_display_o == 8'hC4)
        else $error("cts high with rts low not held as C4");
    a_tx_pattern: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        tx_valid_o |-> tx_data_o == 8'(sent_reg - 1'b1))
        else $error("transmitted character out of order");
    a_rx_poll: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_reg == S_XFER && rx_full_i && !rx_read_o |=> rx_read_o)
        else $error("receive-full not serviced");
    a_echo_mismatch: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        rx_take && rx_data_i != exp_data |=> fail_o && recv_reg == 9'h000)
        else $error("mismatched echo not failed");
    a_slow_rate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(rate_slow_reg) |=> cfg_write_o && cfg_baud_o == BAUD_300 ##1 front_panel_code_display_o == CODE_C6)
        else $error("300 baud pass not configured");
    a_cksum_fail: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ck_end && sum_reg != CHECKSUM_EXPECT |=> fail_o && state_reg == S_CKSUM)
        else $error("bad checksum not flagged C8");
    a_done_code: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(done_o) |-> front_panel_code_display_o == CODE_DONE && !fail_o)
        else $error("completion without code 55");
    a_rx_timeout: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        timed_out |=> fail_o && !exp_valid)
        else $error("echo timeout not failed");
endmodule

/* File: src/serial_loopback_self_test_pkg.sv */
// constants for the serial loopback self-test sequencer
// assumes a 250 MHz system clock and one serial adapter with loopback plug
package serial_loopback_self_test_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // adapter reset pulse and control-line settle times
    localparam int unsigned ARESET_NS = 1000;
    localparam int unsigned ARESET_CYC = (ARESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_NS = 2000;
    localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest wait for one echoed character (a 300 baud character is about 33 ms)
    localparam int unsigned RX_TIMEOUT_NS = 100_000_000;
    localparam int unsigned RX_TIMEOUT_CYC = RX_TIMEOUT_NS / CLK_PERIOD_NS;
    // adapter configuration words
    localparam logic BAUD_9600 = 1'b0;
    localparam logic BAUD_300 = 1'b1;
    localparam logic [3:0] CFG_DATA_BITS = 4'h8;
    localparam logic [1:0] CFG_STOP_BITS = 2'h1;
    localparam logic [4:0] CFG_CLK_MULT = 5'h10;
    // pattern and buffering
    localparam logic [8:0] CHAR_COUNT = 9'h100;
    localparam int unsigned FIFO_WIDTH = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    // program memory checksum
    localparam int unsigned ROM_AW = 10;
    localparam logic [10:0] ROM_WORDS = 11'h400;
    localparam logic [7:0] CHECKSUM_EXPECT = 8'h00;
    // display codes
    localparam logic [7:0] CODE_IDLE = 8'h00;
    localparam logic [7:0] CODE_C1 = 8'hC1;
    localparam logic [7:0] CODE_C5 = 8'hC5;
    localparam logic [7:0] CODE_C6 = 8'hC6;
    localparam logic [7:0] CODE_C8 = 8'hC8;
    localparam logic [7:0] CODE_DONE = 8'h55;
endpackage

/* File: bench/loopback_adapter_model.sv */
// behavioural serial adapter whose tx, rx and modem leads are looped through a plug
// assumes the sequencer's clock; echoes come back later at the slow rate
`timescale 1ns/1ps
module loopback_adapter_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control from the sequencer
    input wire logic adapter_reset_i,
    input wire logic cfg_write_i,
    input wire logic cfg_baud_i,
    input wire logic rts_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic rx_read_i,
    // faults ordered by the bench
    input wire logic flip_dcd_i,
    input wire logic flip_cts_i,
    input wire logic [8:0] corrupt_i,
    input wire logic mute_i,
    // toward the sequencer
    output logic dcd_o,
    output logic cts_o,
    output logic tx_ready_o,
    output logic rx_full_o,
    output logic [7:0] rx_data_o,
    // observations for the bench
    output logic baud_o,
    output int cfg_count_o,
    output int max_out_o
);
    logic [7:0] q_d[$];
    int q_t[$];
    int cyc;
    logic used_reg;
    logic [7:0] last_reg;
    // the plug straps rts to dcd and cts; a flip stands for a broken lead
    assign dcd_o = rts_i ^ flip_dcd_i;
    assign cts_o = rts_i ^ flip_cts_i;
    // the transmitter pauses now and then at the slow rate, so the fifo must hold back
    assign tx_ready_o = !adapter_reset_i && !(baud_o && cyc[4:3] == 2'b11);
    // an empty receive buffer shows no stale byte
    assign rx_data_o = rx_full_o ? last_reg : ~last_reg;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_d.delete();
            q_t.delete();
            cyc <= 0;
            used_reg <= 1'b0;
            last_reg <= 8'h00;
            rx_full_o <= 1'b0;
            baud_o <= 1'b0;
            cfg_count_o <= 0;
            max_out_o <= 0;
        end else begin
            cyc <= cyc + 1;
            if (cfg_write_i) begin
                baud_o <= cfg_baud_i;
                cfg_count_o <= cfg_count_o + 1;
            end
            if (tx_valid_i && !adapter_reset_i) begin
                q_d.push_back(tx_data_i);
                q_t.push_back(cyc + (baud_o ? 40 : 4));
            end
            if (!corrupt_i[8]) begin
                used_reg <= 1'b0;
            end
            if (rx_read_i) begin
                rx_full_o <= 1'b0;
            end else if (!rx_full_o && q_d.size() > 0 && cyc >= q_t[0]) begin
                if (!mute_i) begin
                    rx_full_o <= 1'b1;
                    last_reg <= (corrupt_i[8] && !used_reg && q_d[0] == corrupt_i[7:0]) ? ~q_d[0] : q_d[0];
                end
                if (corrupt_i[8] && q_d[0] == corrupt_i[7:0]) begin
                    used_reg <= 1'b1;
                end
                void'(q_d.pop_front());
                void'(q_t.pop_front());
            end
            if (q_d.size() + int'(rx_full_o) > max_out_o) begin
                max_out_o <= q_d.size() + int'(rx_full_o);
            end
        end
    end
endmodule

/* File: bench/tb_serial_loopback_self_test.sv */
// self-checking bench for the loopback self-test sequencer
// assumes the adapter model beside it and a small rom made here whose bytes sum to 00
`timescale 1ns/1ps
module tb_serial_loopback_self_test
    import serial_loopback_self_test_pkg::*;
;
    typedef struct packed {logic [7:0] code; logic fd; logic fc; logic rts; logic [7:0] nxt;} row_t;
    logic ref_clk_i, rst_n_i, adapter_reset_o, cfg_write_o, cfg_baud_o, rts_o, dcd_i, cts_i;
    logic tx_valid_o, tx_ready_i, rx_full_i, rx_read_o, fail_o, done_o, flip_dcd, flip_cts, mute, rom_bad;
    logic baud_seen;
    logic [3:0] cfg_data_bits_o;
    logic [1:0] cfg_stop_bits_o;
    logic [4:0] cfg_clk_mult_o;
    logic [7:0] tx_data_o, rx_data_i, rom_data_i, front_panel_code_display_o, tx_next;
    logic [8:0] corrupt;
    logic [ROM_AW-1:0] rom_addr_o, rom_addr_q;
    int n_errors = 0, num_checks = 0, n_ff = 0, cfg_count, max_out;
    // each row breaks one looped lead during its own step
    row_t rows [4] = '{'{8'hC1, 1'b1, 1'b0, 1'b1, 8'hC2}, '{8'hC2, 1'b0, 1'b1, 1'b1, 8'hC3},
                       '{8'hC3, 1'b1, 1'b0, 1'b0, 8'hC4}, '{8'hC4, 1'b0, 1'b1, 1'b0, 8'hC5}};
    serial_loopback_self_test #(.TIMEOUT_CYC(200)) dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .adapter_reset_o(adapter_reset_o), .cfg_write_o(cfg_write_o), .cfg_baud_o(cfg_baud_o),
        .cfg_data_bits_o(cfg_data_bits_o), .cfg_stop_bits_o(cfg_stop_bits_o), .cfg_clk_mult_o(cfg_clk_mult_o),
        .rts_o(rts_o), .dcd_i(dcd_i), .cts_i(cts_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
        .tx_ready_i(tx_ready_i), .rx_full_i(rx_full_i), .rx_data_i(rx_data_i), .rx_read_o(rx_read_o),
        .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
        .front_panel_code_display_o(front_panel_code_display_o), .fail_o(fail_o), .done_o(done_o));
    loopback_adapter_model adapter (.clk_i(ref_clk_i), .rst_n_i(rst_n_i), .adapter_reset_i(adapter_reset_o),
        .cfg_write_i(cfg_write_o), .cfg_baud_i(cfg_baud_o), .rts_i(rts_o), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .rx_read_i(rx_read_o), .flip_dcd_i(flip_dcd), .flip_cts_i(flip_cts),
        .corrupt_i(corrupt), .mute_i(mute), .dcd_o(dcd_i), .cts_o(cts_i), .tx_ready_o(tx_ready_i),
        .rx_full_o(rx_full_i), .rx_data_o(rx_data_i), .baud_o(baud_seen), .cfg_count_o(cfg_count),
        .max_out_o(max_out));
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // one-cycle rom: data is the low address byte, so 1024 words sum to 00
    always @(posedge ref_clk_i) rom_addr_q <= rom_addr_o;
    always @(negedge ref_clk_i) rom_data_i = rom_addr_q[7:0] ^ {7'h00, rom_bad && rom_addr_q == 10'h005};
    // a pattern runs 00 upward; only a restart may go back to 00
    // looked at on the falling edge, so the strobe has settled after its launching edge
    always @(negedge ref_clk_i) begin
        if (tx_valid_o === 1'b1) begin
            if (tx_data_o !== 8'h00) check(tx_data_o, tx_next);
            if (tx_data_o === 8'hFF) n_ff++;
            tx_next <= tx_data_o + 8'h01;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // which: 0 display shows code, 1 fail set, 2 done set; a bound that runs out ends the run
    task automatic wait_for(input int which, input logic [7:0] code, input int lim);
        int n;
        bit hit;
        n = 0;
        hit = 1'b0;
        while (!hit) begin
            @(negedge ref_clk_i);
            case (which)
                0: hit = (front_panel_code_display_o === code);
                1: hit = (fail_o === 1'b1);
                default: hit = (done_o === 1'b1);
            endcase
            n++;
            if (!hit && n >= lim) begin
                n_errors++;
                $display("CHECK FAILED at %0t: wait %0d timed out, display %h", $time, which, front_panel_code_display_o);
                report_and_stop();
            end
        end
    endtask
    initial begin
        int n;
        rst_n_i = 1'b0;
        flip_dcd = 1'b0;
        flip_cts = 1'b0;
        corrupt = 9'h000;
        mute = 1'b0;
        rom_bad = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        check(front_panel_code_display_o, CODE_IDLE);
        check(adapter_reset_o, 1'b1);
        check({done_o, fail_o, rts_o}, 3'h0);
        rst_n_i = 1'b1;
        n = 0;
        while (adapter_reset_o === 1'b1 && n < 1000) begin
            @(negedge ref_clk_i);
            n++;
        end
        check(n >= ARESET_CYC && n <= ARESET_CYC + 2, 1'b1);
        wait_for(0, CODE_C1, 10);
        @(negedge ref_clk_i);
        check(cfg_count, 1);
        check(baud_seen, BAUD_9600);
        check({cfg_data_bits_o, cfg_stop_bits_o, cfg_clk_mult_o}, {CFG_DATA_BITS, CFG_STOP_BITS, CFG_CLK_MULT});
        for (int i = 0; i < 4; i++) begin
            wait_for(0, rows[i].code, 1200);
            flip_dcd = rows[i].fd;
            flip_cts = rows[i].fc;
            check(rts_o, rows[i].rts);
            wait_for(1, 8'h00, 1200);
            check(front_panel_code_display_o, rows[i].code);
            flip_dcd = 1'b0;
            flip_cts = 1'b0;
            wait_for(0, rows[i].nxt, 1200);
            check(fail_o, 1'b0);
        end
        // a corrupted echo mid-pattern fails the fast transfer, which then reruns
        corrupt = {1'b1, 8'h40};
        wait_for(1, 8'h00, 2000);
        check(front_panel_code_display_o, CODE_C5);
        corrupt = 9'h000;
        wait_for(0, CODE_C6, 8000);
        @(negedge ref_clk_i);
        check(fail_o, 1'b0);
        check(cfg_count, 2);
        check(baud_seen, BAUD_300);
        // a silent receiver at the slow rate must end in a timeout, not a hang
        repeat (100) @(negedge ref_clk_i);
        mute = 1'b1;
        wait_for(1, 8'h00, 2000);
        check(front_panel_code_display_o, CODE_C6);
        mute = 1'b0;
        wait_for(0, CODE_C8, 20000);
        check(fail_o, 1'b0);
        check(max_out >= FIFO_DEPTH && max_out <= FIFO_DEPTH + 1, 1'b1);
        rom_bad = 1'b1;
        wait_for(1, 8'h00, 3000);
        check(front_panel_code_display_o, CODE_C8);
        rom_bad = 1'b0;
        wait_for(2, 8'h00, 5000);
        check(front_panel_code_display_o, CODE_DONE);
        check(fail_o, 1'b0);
        check(n_ff >= 2, 1'b1);
        // second reset after completion starts the whole sequence again
        rst_n_i = 1'b0;
        @(negedge ref_clk_i);
        check({front_panel_code_display_o, adapter_reset_o, done_o}, {CODE_IDLE, 2'b10});
        rst_n_i = 1'b1;
        wait_for(0, CODE_C1, 400);
        check(cfg_baud_o, BAUD_9600);
        report_and_stop();
    end
endmodule
